/* hdl/tsp_pkg.sv */
package tsp_pkg;

  localparam logic [3:0] BYTE_BITS   = 4'h8;
  // command bits D7..D2 already shifted in when the sixteenth pulse rises
  localparam logic [3:0] APPLY_COUNT = 4'h6;
  localparam int         RESULT_BITS = 12;
  localparam int         TX_BITS     = 16;
  localparam logic [2:0] CH_SLEEP    = 3'h7;
  localparam logic [7:0] CMD_RESET   = 8'h00;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_AACK = 8'h04,
    ST_WR   = 8'h08,
    ST_WACK = 8'h10,
    ST_RD   = 8'h20,
    ST_RACK = 8'h40,
    ST_IGN  = 8'h80
  } tsp_state_t;

  // control_command layout, bit 7 down to bit 0
  typedef struct packed {
    logic       start;
    logic [2:0] channelSelect;
    logic       spareBitHi;
    logic       powerDownSelect;
    logic       mode;
    logic       spareBitLo;
  } tsp_cmd_t;

  typedef struct packed {
    logic platesOpen;
    logic penOut;
    logic penOe;
  } tsp_panel_t;

  // state clocked by the serial clock itself
  typedef struct packed {
    logic sampled;
    logic toggle;
  } tsp_link_t;

endpackage : tsp_pkg

/* hdl/tsp_i2c_slave.sv */
`timescale 1ns/100ps

module tsp_i2c_slave #(
  parameter logic [5:0] ADDR_HIGH = 6'h2A  // arbitrary value
) (
  input  wire  logic                  clk,
  input  wire  logic                  rst,
  input  wire  logic                  sclClk,
  input  wire  logic                  sdaIn,
  output logic                        sdaOut,
  output logic                        sdaOe,
  input  wire  logic                  addrSelectBit,
  input  wire  logic                  penLevel,
  input  wire  logic [11:0]           convData,
  output logic                        convStart,
  output logic [2:0]                  channelSelect,
  output logic                        powerDownSelect,
  output logic                        resolution8,
  output logic                        sleeping,
  output logic                        platesOpen,
  output logic                        penInterruptOut,
  output logic                        penInterruptOe
);

  typedef struct packed {
    tsp_pkg::tsp_state_t   state;
    logic [3:0]            bitCnt;
    logic [7:0]            rxShift;
    logic [15:0]           txShift;
    logic                  readDir;
    logic                  masterAck;
    tsp_pkg::tsp_cmd_t     controlCommand;
    logic                  sleep;
    logic                  sleepHiZ;
    logic                  sdaOut;
    logic                  sdaOe;
    logic                  convStart;
    tsp_pkg::tsp_panel_t   panel;
    logic                  sclMeta;
    logic                  sclSync;
    logic                  sclPrev;
    logic                  sdaMeta;
    logic                  sdaSync;
    logic                  sdaPrev;
    logic                  togMeta;
    logic                  togSync;
    logic                  togPrev;
    logic                  selMeta;
    logic                  selSync;
    logic                  penMeta;
    logic                  penSync;
  } tsp_regs_t;

  localparam tsp_regs_t REGS_RESET = '{
    state:          tsp_pkg::ST_IDLE,
    bitCnt:         4'h0,
    rxShift:        8'h00,
    txShift:        16'h0000,
    readDir:        1'b0,
    masterAck:      1'b0,
    controlCommand: tsp_pkg::CMD_RESET,
    sleep:          1'b0,
    sleepHiZ:       1'b0,
    sdaOut:         1'b0,
    sdaOe:          1'b0,
    convStart:      1'b0,
    panel:          3'h1,
    sclMeta:        1'b1,
    sclSync:        1'b1,
    sclPrev:        1'b1,
    sdaMeta:        1'b1,
    sdaSync:        1'b1,
    sdaPrev:        1'b1,
    togMeta:        1'b0,
    togSync:        1'b0,
    togPrev:        1'b0,
    selMeta:        1'b0,
    selSync:        1'b0,
    penMeta:        1'b1,
    penSync:        1'b1
  };

  tsp_pkg::tsp_link_t link;
  tsp_regs_t          s;
  tsp_regs_t          next_s;

  // formats a fresh result MSB first, padded with zeros
  function automatic logic [15:0] tsp_format(input logic [11:0] data,
                                             input logic        is8);
    if (is8) begin
      tsp_format = {data[11:4], 8'h00};
    end else begin
      tsp_format = {data, 4'h0};
    end
  endfunction : tsp_format

  // the serial clock only samples the bit and flags it by a toggle;
  // the reset is asynchronous here because this clock may stand still
  always_ff @(posedge sclClk or posedge rst) begin
    if (rst) begin
      link <= 2'b00;
    end else begin
      link.sampled <= sdaIn;
      link.toggle  <= ~link.toggle;
    end
  end

  logic riseEv;
  logic fallEv;
  logic startEv;
  logic stopEv;
  logic addrMatch;

  assign riseEv    = s.togSync ^ s.togPrev;
  assign fallEv    = s.sclPrev & ~s.sclSync;
  assign startEv   = s.sclSync & s.sclPrev & s.sdaPrev & ~s.sdaSync;
  assign stopEv    = s.sclSync & s.sclPrev & ~s.sdaPrev & s.sdaSync;
  assign addrMatch = (s.rxShift[7:1] == {ADDR_HIGH, s.selSync});

  always_comb begin
    next_s           = s;
    next_s.convStart = 1'b0;
    next_s.sclMeta   = sclClk;
    next_s.sclSync   = s.sclMeta;
    next_s.sclPrev   = s.sclSync;
    next_s.sdaMeta   = sdaIn;
    next_s.sdaSync   = s.sdaMeta;
    next_s.sdaPrev   = s.sdaSync;
    next_s.togMeta   = link.toggle;
    next_s.togSync   = s.togMeta;
    next_s.togPrev   = s.togSync;
    next_s.selMeta   = addrSelectBit;
    next_s.selSync   = s.selMeta;
    next_s.penMeta   = penLevel;
    next_s.penSync   = s.penMeta;

    // every drive change below waits for a falling SCL edge
    case (s.state)
      tsp_pkg::ST_IDLE: begin
        next_s.sdaOe = 1'b0;
      end
      tsp_pkg::ST_ADDR: begin
        if (riseEv) begin
          next_s.rxShift = {s.rxShift[6:0], link.sampled};
          next_s.bitCnt  = s.bitCnt + 4'h1;
        end else if (fallEv && s.bitCnt == tsp_pkg::BYTE_BITS) begin
          next_s.bitCnt  = 4'h0;
          next_s.readDir = s.rxShift[0];
          if (addrMatch) begin
            next_s.sdaOe = 1'b1;
            next_s.state = tsp_pkg::ST_AACK;
            // no conversion while asleep
            next_s.convStart = s.rxShift[0] & ~s.sleep;
          end else begin
            next_s.state = tsp_pkg::ST_IGN;
          end
        end
      end
      tsp_pkg::ST_AACK: begin
        if (fallEv) begin
          if (s.readDir) begin
            // result is taken one SCL period after the conversion request
            next_s.txShift = tsp_format(convData,
                                        s.controlCommand.mode);
            next_s.sdaOe   = ~next_s.txShift[15];
            next_s.txShift = {next_s.txShift[14:0], 1'b0};
            next_s.state   = tsp_pkg::ST_RD;
          end else begin
            next_s.sdaOe = 1'b0;
            next_s.state = tsp_pkg::ST_WR;
          end
        end
      end
      tsp_pkg::ST_WR: begin
        if (riseEv) begin
          next_s.rxShift = {s.rxShift[6:0], link.sampled};
          next_s.bitCnt  = s.bitCnt + 4'h1;
          if (s.bitCnt == tsp_pkg::APPLY_COUNT) begin
            // sixteenth pulse: D7..D1 are known, D0 is don't care
            next_s.controlCommand = {s.rxShift[5:0], link.sampled,
                                     1'b0};
            if (!s.rxShift[5] &&
                s.rxShift[4:2] == tsp_pkg::CH_SLEEP) begin
              next_s.sleep    = 1'b1;
              next_s.sleepHiZ = link.sampled;
            end else begin
              next_s.sleep = 1'b0;
            end
          end
        end else if (fallEv && s.bitCnt == tsp_pkg::BYTE_BITS) begin
          next_s.sdaOe  = 1'b1;
          next_s.bitCnt = 4'h0;
          next_s.state  = tsp_pkg::ST_WACK;
        end
      end
      tsp_pkg::ST_WACK: begin
        if (fallEv) begin
          // master is expected to close with STOP or repeated START
          next_s.sdaOe = 1'b0;
          next_s.state = tsp_pkg::ST_IGN;
        end
      end
      tsp_pkg::ST_RD: begin
        if (riseEv) begin
          next_s.bitCnt = s.bitCnt + 4'h1;
        end else if (fallEv) begin
          if (s.bitCnt == tsp_pkg::BYTE_BITS) begin
            next_s.sdaOe  = 1'b0;
            next_s.bitCnt = 4'h0;
            next_s.state  = tsp_pkg::ST_RACK;
          end else begin
            next_s.sdaOe   = ~s.txShift[15];
            next_s.txShift = {s.txShift[14:0], 1'b0};
          end
        end
      end
      tsp_pkg::ST_RACK: begin
        if (riseEv) begin
          next_s.masterAck = ~link.sampled;
        end else if (fallEv) begin
          if (s.masterAck) begin
            // beyond the result only zero bytes remain
            next_s.sdaOe   = ~s.txShift[15];
            next_s.txShift = {s.txShift[14:0], 1'b0};
            next_s.state   = tsp_pkg::ST_RD;
          end else begin
            next_s.sdaOe = 1'b0;
            next_s.state = tsp_pkg::ST_IGN;
          end
        end
      end
      tsp_pkg::ST_IGN: begin
        next_s.sdaOe = 1'b0;
      end
      default: begin
        next_s.state = tsp_pkg::ST_IDLE;
        next_s.sdaOe = 1'b0;
      end
    endcase

    if (stopEv) begin
      next_s.state     = tsp_pkg::ST_IDLE;
      next_s.sdaOe     = 1'b0;
      next_s.convStart = 1'b0;
    end
    if (startEv) begin
      next_s.state     = tsp_pkg::ST_ADDR;
      next_s.bitCnt    = 4'h0;
      next_s.sdaOe     = 1'b0;
      next_s.convStart = 1'b0;
    end

    next_s.panel.platesOpen = next_s.sleep;
    next_s.panel.penOe      = ~(next_s.sleep & next_s.sleepHiZ);
    next_s.panel.penOut     = next_s.sleep | s.penSync;
  end

  // reset lands in normal mode, bus released
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= REGS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // SDA is open drain: the line is only ever pulled low
  assign sdaOut          = s.sdaOut;
  assign sdaOe           = s.sdaOe;
  assign convStart       = s.convStart;
  assign channelSelect   = s.controlCommand.channelSelect;
  assign powerDownSelect = s.controlCommand.powerDownSelect;
  assign resolution8     = s.controlCommand.mode;
  assign sleeping        = s.sleep;
  assign platesOpen      = s.panel.platesOpen;
  assign penInterruptOut = s.panel.penOut;
  assign penInterruptOe  = s.panel.penOe;

endmodule : tsp_i2c_slave

/* bench/tsp_master_model.sv */
`timescale 1ns/100ps
// SCL is made here and stands still high between frames
module tsp_master_model #(
  parameter int QUARTER = 630  // 15.75 periods of the 40 ns clk, phase unrelated to clk
) (
  output logic      sclClk,
  output logic      sdaLow,
  input  wire logic sdaLine
);
  initial begin
    sclClk = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic start_cond();
    sdaLow = 1'b0;
    #QUARTER sclClk = 1'b1;
    #QUARTER sdaLow = 1'b1;
    #QUARTER sclClk = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    sdaLow = 1'b1;
    #QUARTER sclClk = 1'b1;
    #QUARTER sdaLow = 1'b0;
    #QUARTER;
  endtask : stop_cond
  // data moves mid-low so the slave's late release never races it
  task automatic bit_cycle(input logic b, output logic r);
    #QUARTER sdaLow = ~b;
    #QUARTER sclClk = 1'b1;
    #QUARTER r = sdaLine;
    #QUARTER sclClk = 1'b0;
  endtask : bit_cycle
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], r);
    end
    bit_cycle(1'b1, r);
    ack = ~r;
  endtask : send_byte
  task automatic recv_byte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, r);
      d[i] = r;
    end
    bit_cycle(~ackIt, r);
  endtask : recv_byte
endmodule : tsp_master_model

/* bench/tsp_i2c_slave_checker.sv */
`timescale 1ns/100ps
module tsp_i2c_slave_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sclClk,
  input wire logic        sdaIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        convStart,
  input wire logic [2:0]  channelSelect,
  input wire logic        resolution8,
  input wire logic        sleeping,
  input wire logic        platesOpen,
  input wire logic        penInterruptOut,
  input wire logic        penInterruptOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start;
    sclClk && $past(sclClk) && $fell(sdaIn);
  endsequence
  sequence s_stop;
    sclClk && $past(sclClk) && $rose(sdaIn);
  endsequence
  a_start_released: assert property (s_start |-> !sdaOe [*8])
    else $error("slave drives SDA after START");
  a_stop_released: assert property (s_stop |-> !sdaOe [*4])
    else $error("slave drives SDA after STOP");
  a_oe_scl_low: assert property (!$past(rst) && $changed(sdaOe)
    |-> !sclClk && !$past(sclClk, 2)) else $error("SDA moved in SCL high");
  a_drive_low_only: assert property (!sdaOut)
    else $error("SDA driven high");
  a_conv_pulse: assert property (convStart
    |-> !sleeping && !sclClk ##1 !convStart) else $error("bad conversion");
  a_plates_sleep: assert property (platesOpen == sleeping)
    else $error("plates and sleep disagree");
  a_sleep_pen_state: assert property (sleeping && $past(sleeping)
    && $stable(resolution8) |-> penInterruptOe == !resolution8
    && (resolution8 || penInterruptOut)) else $error("pen pin in sleep");
  a_normal_pen: assert property (!sleeping && !$past(sleeping)
    |-> penInterruptOe) else $error("pen pin released in normal mode");
  a_ctrl_on_rise: assert property (!$past(rst) && ($changed(sleeping)
    || $changed(channelSelect) || $changed(resolution8))
    |-> sclClk && $past(sclClk)) else $error("command applied off SCL high");
endmodule : tsp_i2c_slave_checker

bind tsp_i2c_slave tsp_i2c_slave_checker chk (.clk(clk), .rst(rst),
  .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .convStart(convStart), .channelSelect(channelSelect),
  .resolution8(resolution8), .sleeping(sleeping), .platesOpen(platesOpen),
  .penInterruptOut(penInterruptOut), .penInterruptOe(penInterruptOe));

/* bench/touch_adc_i2c_slave_port_bench.sv */
`timescale 1ns/100ps
module touch_adc_i2c_slave_port_bench;
  localparam logic [5:0] ADDR_HIGH = 6'h15;  // arbitrary value
  logic        clk = 1'b0, rst = 1'b1, addrSelectBit = 1'b1, penLevel = 1'b0;
  logic [11:0] convData = 12'h000;
  logic        sclClk, sdaLow, sdaLine, sdaOut, sdaOe, convStart;
  logic        powerDownSelect, resolution8, sleeping, platesOpen;
  logic        penInterruptOut, penInterruptOe;
  logic [2:0]  channelSelect;
  int          fail_count = 0, total_checks = 0, convCount = 0;
  always #20 clk = ~clk;
  assign sdaLine = ~(sdaLow | (sdaOe & ~sdaOut));
  always @(posedge clk) if (convStart === 1'b1) convCount++;
  tsp_i2c_slave #(.ADDR_HIGH(ADDR_HIGH)) DUT (.clk(clk), .rst(rst),
    .sclClk(sclClk), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSelectBit(addrSelectBit), .penLevel(penLevel), .convData(convData),
    .convStart(convStart), .channelSelect(channelSelect),
    .powerDownSelect(powerDownSelect), .resolution8(resolution8),
    .sleeping(sleeping), .platesOpen(platesOpen),
    .penInterruptOut(penInterruptOut), .penInterruptOe(penInterruptOe));
  tsp_master_model m (.sclClk(sclClk), .sdaLow(sdaLow), .sdaLine(sdaLine));
  task automatic compare_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare_val
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  function automatic logic [15:0] exp_read(input logic [11:0] c, input logic is8);
    return is8 ? {c[11:4], 8'h00} : {c, 4'h0};
  endfunction : exp_read
  task automatic check_ctrl(input logic [7:0] cmd, input logic slp);
    compare_val(16'({channelSelect, powerDownSelect, resolution8, sleeping,
      platesOpen}), 16'({cmd[6:4], cmd[2], cmd[1], slp, slp}));
    compare_val(16'({penInterruptOe, penInterruptOut | (slp & cmd[1])}),
      16'({~(slp & cmd[1]), slp | penLevel}));
  endtask : check_ctrl
  task automatic write_cmd(input logic [6:0] addr, input logic [7:0] cmd,
                           input logic expAck);
    logic ack;
    m.start_cond();
    m.send_byte({addr, 1'b0}, ack);
    compare_val(16'(ack), 16'(expAck));
    m.send_byte(cmd, ack);
    compare_val(16'(ack), 16'(expAck));
    m.stop_cond();
    repeat (4) @(posedge clk);
  endtask : write_cmd
  task automatic read_once(input logic slp, input logic is8);
    logic        ack;
    logic [7:0]  b0, b1;
    logic [11:0] c;
    int          n;
    c = 12'($urandom);
    n = convCount;
    b1 = 8'h00;
    @(posedge clk) #1 convData = c;
    m.start_cond();
    m.send_byte({ADDR_HIGH, addrSelectBit, 1'b1}, ack);
    compare_val(16'(ack), 16'h0001);
    m.recv_byte(~is8, b0);
    if (!is8) m.recv_byte(1'b0, b1);
    if (!slp) compare_val({b0, b1}, exp_read(c, is8));
    compare_val(16'(convCount - n), slp ? 16'h0000 : 16'h0001);
  endtask : read_once
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    logic [7:0] cmd;
    logic [7:0] cmdList [4] = '{8'h80, 8'h72, 8'h70, 8'hD2};
    void'($urandom(32'hC844));
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    check_ctrl(8'h00, 1'b0);
    write_cmd({ADDR_HIGH, ~addrSelectBit}, 8'h84, 1'b0);
    check_ctrl(8'h00, 1'b0);
    $display("test reset and mismatch done");
    // first command keeps power-down clear; then sleep, sleep again, wake
    for (int i = 0; i < 10; i++) begin
      cmd = (i < 4) ? cmdList[i] : 8'($urandom);
      @(posedge clk) #1 penLevel = 1'($urandom);
      write_cmd({ADDR_HIGH, addrSelectBit}, cmd, 1'b1);
      check_ctrl(cmd, cmd[7:4] == 4'h7);
      read_once(cmd[7:4] == 4'h7, cmd[1]);
      read_once(cmd[7:4] == 4'h7, cmd[1]);
      m.stop_cond();
      $display("test command %h done", cmd);
    end
    print_verdict();
  end
endmodule : touch_adc_i2c_slave_port_bench
